// File: hdl/light_curtain_status_indicator.sv
// Status indication for transmitter LEDs and receiver LEDs and display.
// Assumes status pins from sensing and gating logic; async pins resync.
`timescale 1ns/1ps
`include "light_curtain_cfg.svh"
module light_curtain_status_indicator
	import light_curtain_pkg::*;
#(
	parameter int RECOVER_CYCLES  = `RECOVER_CYCLES,
	parameter int RANGE_CYCLES    = `RANGE_CYCLES,
	parameter int ALIGN_CYCLES    = `ALIGN_CYCLES,
	parameter int SELFTEST_CYCLES = `SELFTEST_CYCLES,
	parameter int PHASE_CYCLES    = `PHASE_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       txFault,
	input  wire logic       reducedRange,
	input  wire logic       channel_two,
	input  wire logic       safety_output_pair,
	input  wire fault_t     faultIn,
	input  wire logic       faultValid,
	input  wire interlock_t restart_interlock,
	input  wire logic       controllerGating,
	input  wire logic       process_gating,
	input  wire logic       blankTaught,
	input  wire logic       teachPending,
	input  wire logic       overrideActive,
	input  wire logic       opModeFive,
	input  wire logic [2:0] opModeNum,
	input  wire logic       syncBeamA,
	input  wire logic       syncBeamB,
	input  wire logic       aligned,
	input  wire logic       scanDone,
	input  wire logic [7:0] responseMs,
	input  wire logic [2:0] thirdAllClear,
	input  wire logic [2:0] thirdAnyClear,
	output bicolour_t       txLed1,
	output logic            txLed2,
	output bicolour_t       rxLed1,
	output logic            rxYellow,
	output logic            rxBlue,
	output logic [6:0]      segments,
	output logic            inSync,
	output logic            lockedOut,
	output logic            errorActive,
	output logic            scanStrobe
);
	logic slowLvl, fastLvl, slowWrap, fastWrap;
	logic shortLvl;

	// Shared flash sources
	flash_timer #(.HALF(`SLOW_HALF)) slowGen (
		.clock  (clock),
		.sys_rst(sys_rst),
		.level  (slowLvl),
		.wrap   (slowWrap)
	);
	flash_timer #(.HALF(`FAST_HALF)) fastGen (
		.clock  (clock),
		.sys_rst(sys_rst),
		.level  (fastLvl),
		.wrap   (fastWrap)
	);

	// Pin sync: three flops, accept when stages two and three agree
	logic [2:0] s1_q, s2_q, s3_q, pin_q, pin_d, pinRaw;
	assign pinRaw = {syncBeamB, syncBeamA, reducedRange};
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			pin_q <= '0;
		end else begin
			s1_q  <= pinRaw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			pin_q <= pin_d;
		end
	end

	// Short blip: on for one fast half period in every eight, only while the slow level is on
	logic [2:0] blip_q, blip_d;
	always_comb begin
		blip_d   = fastWrap ? blip_q + 3'h1 : blip_q;
		shortLvl = slowLvl && (blip_q == 3'h0);
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) blip_q <= '0;
		else blip_q <= blip_d;
	end

	// Timers: range flash window, error recovery, alignment, display phase
	logic [`TIMER_W-1:0] rng_q, rng_d, rec_q, rec_d;
	logic [`TIMER_W-1:0] alg_q, alg_d, ph_q, ph_d;
	logic                rngDone_q, rngDone_d;
	logic                err_q, err_d, lock_q, lock_d;
	err_class_t          cls_q, cls_d;
	logic [7:0]          code_q, code_d;
	disp_state_t         st_q, st_d;
	logic [1:0]          step_q, step_d;
	logic                fieldFree, phaseEnd;

	assign fieldFree = &thirdAllClear;
	assign phaseEnd  = (ph_q == `TIMER_W'(PHASE_CYCLES - 1));

	// Range flash window, error capture and recovery
	always_comb begin
		rngDone_d = rngDone_q;
		rng_d     = rng_q;
		if (!rngDone_q) begin
			rng_d     = rng_q + `TIMER_W'(1);
			rngDone_d = (rng_q == `TIMER_W'(RANGE_CYCLES - 1));
		end
		err_d  = err_q;
		lock_d = lock_q;
		cls_d  = cls_q;
		code_d = code_q;
		rec_d  = '0;
		if (faultValid && !lock_q) begin
			err_d  = 1'b1;
			cls_d  = faultIn.errClass;
			code_d = faultIn.code;
			lock_d = faultIn.blocking;
		end else if (err_q && !lock_q) begin
			rec_d = rec_q + `TIMER_W'(1);
			if (rec_q == `TIMER_W'(RECOVER_CYCLES - 1)) begin
				err_d = 1'b0;
				rec_d = '0;
			end
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rng_q     <= '0;
			rngDone_q <= 1'b0;
			err_q     <= 1'b0;
			lock_q    <= 1'b0;
			cls_q     <= ERR_NONE;
			code_q    <= '0;
			rec_q     <= '0;
		end else begin
			rng_q     <= rng_d;
			rngDone_q <= rngDone_d;
			err_q     <= err_d;
			lock_q    <= lock_d;
			cls_q     <= cls_d;
			code_q    <= code_d;
			rec_q     <= rec_d;
		end
	end

	// Display sequencer
	always_comb begin
		st_d   = st_q;
		step_d = step_q;
		ph_d   = ph_q + `TIMER_W'(1);
		alg_d  = '0;
		unique case (st_q)
			DSP_SELFTEST: begin
				if (ph_q == `TIMER_W'(SELFTEST_CYCLES - 1)) begin
					st_d = DSP_RESPONSE;
					ph_d = '0;
				end
			end
			DSP_RESPONSE: begin
				if (phaseEnd) begin
					ph_d   = '0;
					step_d = step_q + 2'h1;
					if (step_q == 2'h2) begin
						st_d   = DSP_MODE;
						step_d = '0;
					end
				end
			end
			DSP_MODE: begin
				ph_d = '0;
				if (!fieldFree) alg_d = alg_q + `TIMER_W'(1);
				if (!aligned || alg_q == `TIMER_W'(ALIGN_CYCLES - 1))
					st_d = DSP_ALIGN;
			end
			DSP_ALIGN: begin
				ph_d = '0;
				if (fieldFree) alg_d = alg_q + `TIMER_W'(1);
				if (aligned && alg_q == `TIMER_W'(ALIGN_CYCLES - 1))
					st_d = DSP_MODE;
			end
			DSP_ERROR: begin
				if (phaseEnd) begin
					ph_d   = '0;
					step_d = step_q + 2'h1;
					if (step_q == 2'h2) step_d = '0;
				end
			end
		endcase
		if (err_q && st_q != DSP_SELFTEST && st_q != DSP_ERROR) begin
			st_d   = DSP_ERROR;
			step_d = '0;
			ph_d   = '0;
		end else if (!err_q && st_q == DSP_ERROR) begin
			st_d = DSP_MODE;
			ph_d = '0;
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_q   <= DSP_SELFTEST;
			step_q <= '0;
			ph_q   <= '0;
			alg_q  <= '0;
		end else begin
			st_q   <= st_d;
			step_q <= step_d;
			ph_q   <= ph_d;
			alg_q  <= alg_d;
		end
	end

	// Digit and letter glyphs
	function automatic logic [6:0] digit(input logic [3:0] v);
		logic [6:0] g;
		g = 7'h00;
		case (v)
			4'h0: g = 7'h3f;
			4'h1: g = 7'h06;
			4'h2: g = 7'h5b;
			4'h3: g = 7'h4f;
			4'h4: g = 7'h66;
			4'h5: g = 7'h6d;
			4'h6: g = 7'h7d;
			4'h7: g = 7'h07;
			4'h8: g = 7'h7f;
			4'h9: g = 7'h6f;
			default: g = 7'h79;
		endcase
		return g;
	endfunction : digit

	// Half-turn: swap a<->d, b<->e, c<->f, keep g
	function automatic logic [6:0] rotate(input logic [6:0] s);
		return {s[6], s[2], s[1], s[0], s[5], s[4], s[3]};
	endfunction : rotate

	// Output composition; registered so all outputs come from flops
	bicolour_t  tx1_d, rx1_d;
	logic       tx2_d, yel_d, blu_d, sync_d;
	logic [6:0] seg_d, raw;
	logic [3:0] tens, ones;
	always_comb begin
		tens = 4'(responseMs / 8'd10);
		ones = 4'(responseMs % 8'd10);
		tx1_d.red   = txFault;
		tx1_d.green = !txFault;
		tx2_d = (pin_q[0] && !rngDone_q) ? fastLvl : channel_two;
		rx1_d.green = safety_output_pair && !err_q;
		rx1_d.red   = !rx1_d.green;
		if (err_q && cls_q == ERR_INTERNAL) rx1_d.red = fastLvl;
		else if (err_q) rx1_d.red = slowLvl;
		yel_d = !safety_output_pair && (controllerGating
			|| (restart_interlock.active && restart_interlock.blocked
			&& fieldFree && !restart_interlock.inhibited));
		if (teachPending || overrideActive || lock_q) blu_d = shortLvl;
		else if (process_gating) blu_d = slowLvl;
		else blu_d = blankTaught;
		sync_d = pin_q[1] || pin_q[2];
		raw = 7'h00;
		unique case (st_q)
			DSP_SELFTEST: raw = `SEG_ALL;
			DSP_RESPONSE: raw = (step_q == 2'h0) ? `SEG_T
				: (step_q == 2'h1) ? digit(tens) : digit(ones);
			DSP_MODE: raw = digit(opModeFive ? 4'h5 : 4'h1);
			DSP_ERROR: begin
				if (step_q == 2'h0)
					raw = (cls_q == ERR_INTERNAL) ? `SEG_F
						: (cls_q == ERR_USAGE) ? `SEG_U : `SEG_E;
				else if (step_q == 2'h1) raw = digit(code_q[7:4]);
				else raw = digit(code_q[3:0]);
			end
			DSP_ALIGN: begin
				for (int i = 0; i < 3; i++) begin
					if (thirdAllClear[i] ||
						(thirdAnyClear[i] && slowLvl))
						raw = raw | ((i == 2) ? `SEG_ALIGN_TOP
						: (i == 1) ? `SEG_ALIGN_MID
						: `SEG_ALIGN_BOT);
				end
			end
		endcase
		seg_d = (opModeNum == 3'h4 || opModeNum == 3'h6) ? rotate(raw)
			: raw;
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			txLed1      <= '0;
			txLed2      <= 1'b0;
			rxLed1      <= '0;
			rxYellow    <= 1'b0;
			rxBlue      <= 1'b0;
			segments    <= '0;
			inSync      <= 1'b0;
			lockedOut   <= 1'b0;
			errorActive <= 1'b0;
			scanStrobe  <= 1'b0;
		end else begin
			txLed1      <= tx1_d;
			txLed2      <= tx2_d;
			rxLed1      <= rx1_d;
			rxYellow    <= yel_d;
			rxBlue      <= blu_d;
			segments    <= seg_d;
			inSync      <= sync_d;
			lockedOut   <= lock_q;
			errorActive <= err_q;
			scanStrobe  <= scanDone && sync_d;
		end
	end

	a_lock_sticky: assert property (@(posedge clock) disable iff (sys_rst)
		lock_q |=> lock_q) else $error("lockout released");
	a_green_needs: assert property (@(posedge clock) disable iff (sys_rst)
		rxLed1.green |-> $past(safety_output_pair))
		else $error("green without outputs");
	a_yellow_off: assert property (@(posedge clock) disable iff (sys_rst)
		safety_output_pair |=> !rxYellow)
		else $error("yellow with outputs on");
	a_sync_hold: assert property (@(posedge clock) disable iff (sys_rst)
		(pin_q[1] || pin_q[2]) |=> inSync) else $error("sync lost");
	a_err_locked: assert property (@(posedge clock) disable iff (sys_rst)
		lock_q |-> err_q) else $error("locked but no error");
	a_self_first: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(st_q == DSP_RESPONSE) |-> $past(st_q) == DSP_SELFTEST)
		else $error("response time skipped self test");
	a_tx_red: assert property (@(posedge clock) disable iff (sys_rst)
		txFault |=> txLed1.red && !txLed1.green)
		else $error("tx fault not red");
	a_err_show: assert property (@(posedge clock) disable iff (sys_rst)
		(err_q && st_q == DSP_MODE) |=> st_q == DSP_ERROR)
		else $error("error not displayed");
endmodule : light_curtain_status_indicator

// File: shared/light_curtain_cfg.svh
// Constants for the light curtain status indicator.
// Assumes a 125 MHz system clock; included by the indicator, the flash timer and the bench.
// Behaviour
// - Transmitter LED dark, red fault, green normal
// - Green LED flashes 10 s, then shows channel
// - Receiver LED red outputs off, green on
// - External error flashes red near 1 Hz
// - Internal error flashes red near 10 Hz
// - Yellow on when interlock blocked, field free
// - Yellow on when gating asserted, outputs off
// - Yellow dark otherwise
// - Blue off, steady, slow or short flash
// - Normal display shows operating mode digit
// - Modes four and six rotate characters
// - Self test all segments, then response time
// - Error letter then code, cyclic
// - Non-locking errors clear after 10 s
// - Blocking errors lock until power removed
// - Alignment mode unaligned or 5 s interrupted
// - Segments map upper, middle, lower thirds
// - Sync held while one sync beam free
// - Response time follows scan length
// - Segment on/flash/off; revert after 5 s free
`ifndef LIGHT_CURTAIN_CFG_SVH
`define LIGHT_CURTAIN_CFG_SVH
`define CLK_HZ          125000000
`define TIMER_W         31
`define SLOW_FLASH_HZ   1
`define FAST_FLASH_HZ   10
`define SLOW_HALF       (`CLK_HZ / (2 * `SLOW_FLASH_HZ))
`define FAST_HALF       (`CLK_HZ / (2 * `FAST_FLASH_HZ))
`define RANGE_FLASH_S   10
`define RECOVER_S       10
`define ALIGN_S         5
`define SELFTEST_S      1
`define PHASE_S         1
`define RANGE_CYCLES    (`RANGE_FLASH_S * `CLK_HZ)
`define RECOVER_CYCLES  (`RECOVER_S * `CLK_HZ)
`define ALIGN_CYCLES    (`ALIGN_S * `CLK_HZ)
`define SELFTEST_CYCLES (`SELFTEST_S * `CLK_HZ)
`define PHASE_CYCLES    (`PHASE_S * `CLK_HZ)
`define SHORT_ON_DIV    8
// Seven-segment codes, bit order gfedcba
`define SEG_ALL         7'h7f
`define SEG_T           7'h78
`define SEG_F           7'h71
`define SEG_E           7'h79
`define SEG_U           7'h3e
`define SEG_ALIGN_TOP   7'h01
`define SEG_ALIGN_MID   7'h40
`define SEG_ALIGN_BOT   7'h08
`endif

// File: shared/light_curtain_pkg.sv
// Types for the light curtain status indicator.
// Assumes the constants header sits beside it.
package light_curtain_pkg;
	typedef enum logic [1:0] {
		ERR_NONE     = 2'h0,
		ERR_INTERNAL = 2'h1,
		ERR_EXTERNAL = 2'h2,
		ERR_USAGE    = 2'h3
	} err_class_t;

	typedef enum logic [4:0] {
		DSP_SELFTEST = 5'h01,
		DSP_RESPONSE = 5'h02,
		DSP_MODE     = 5'h04,
		DSP_ERROR    = 5'h08,
		DSP_ALIGN    = 5'h10
	} disp_state_t;

	typedef struct packed {
		logic       red;
		logic       green;
	} bicolour_t;

	typedef struct packed {
		err_class_t errClass;
		logic       blocking;
		logic [7:0] code;
	} fault_t;

	typedef struct packed {
		logic       inhibited;
		logic       active;
		logic       blocked;
	} interlock_t;
endpackage : light_curtain_pkg

// File: hdl/flash_timer.sv
// Free-running flash generator: toggles a level every HALF cycles.
// Assumes one clock domain and asynchronous active-high reset.
`timescale 1ns/1ps
`include "light_curtain_cfg.svh"
module flash_timer #(
	parameter int HALF = 2
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	output logic      level,
	output logic      wrap
);
	logic [`TIMER_W-1:0] cnt_q, cnt_d;
	logic                lvl_q, lvl_d;

	// Count to the half period, then flip
	always_comb begin
		wrap  = (cnt_q == `TIMER_W'(HALF - 1));
		cnt_d = wrap ? '0 : cnt_q + `TIMER_W'(1);
		lvl_d = wrap ? ~lvl_q : lvl_q;
	end

	// Restarts cleanly on reset
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
			lvl_q <= 1'b1; // On phase first, so a flash shows at once
		end else begin
			cnt_q <= cnt_d;
			lvl_q <= lvl_d;
		end
	end

	assign level = lvl_q;
endmodule : flash_timer

// File: tb/machine_control.sv
// Machine control stand-in: paces beam scans for the indicator.
// Assumes the bench clock and reset; drives on the falling edge.
`timescale 1ns/1ps
module machine_control #(
	parameter int SCAN = 16
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	output logic      scanDone
);
	logic [7:0] scanCnt;

	// One-cycle pulse at each scan end; length fixes response time
	always @(negedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			scanCnt  <= 8'h00;
			scanDone <= 1'b0;
		end else begin
			scanDone <= (scanCnt == 8'(SCAN - 1));
			scanCnt  <= (scanCnt == 8'(SCAN - 1)) ? 8'h00 : scanCnt + 8'h01;
		end
	end
endmodule : machine_control

// File: tb/light_curtain_status_indicator_tb.sv
// Self-checking bench for the status indicator.
// Assumes shortened interval parameters; flash periods stay too long to see.
`timescale 1ns/1ps
`include "light_curtain_cfg.svh"
module light_curtain_status_indicator_tb
	import light_curtain_pkg::*;
;
	localparam int RC = 200;
	logic clock = 1'b0, sys_rst = 1'b1, txFault = 1'b0, reducedRange = 1'b1;
	logic channel_two = 1'b0, safety_output_pair = 1'b0, faultValid = 1'b0;
	logic controllerGating = 1'b0, process_gating = 1'b0, blankTaught = 1'b0;
	logic teachPending = 1'b0, overrideActive = 1'b0, opModeFive = 1'b0;
	logic syncBeamA = 1'b1, syncBeamB = 1'b1, aligned = 1'b1, scanDone;
	logic [2:0] opModeNum = 3'h1, thirdAllClear = 3'h7, thirdAnyClear = 3'h7;
	logic [7:0] responseMs = 8'h12;
	fault_t faultIn = '0;
	interlock_t restart_interlock = '0;
	bicolour_t txLed1, rxLed1;
	logic txLed2, rxYellow, rxBlue, inSync, lockedOut, errorActive;
	logic scanStrobe;
	logic [6:0] segments;
	int miscompares = 0, n_checks = 0;

	always #4 clock = ~clock;

	light_curtain_status_indicator #(.RECOVER_CYCLES(RC),
		.RANGE_CYCLES(100), .ALIGN_CYCLES(30), .SELFTEST_CYCLES(40),
		.PHASE_CYCLES(20)) dut (.clock(clock), .sys_rst(sys_rst),
		.txFault(txFault), .reducedRange(reducedRange),
		.channel_two(channel_two), .safety_output_pair(safety_output_pair),
		.faultIn(faultIn), .faultValid(faultValid),
		.restart_interlock(restart_interlock),
		.controllerGating(controllerGating), .process_gating(process_gating),
		.blankTaught(blankTaught), .teachPending(teachPending),
		.overrideActive(overrideActive), .opModeFive(opModeFive),
		.opModeNum(opModeNum), .syncBeamA(syncBeamA), .syncBeamB(syncBeamB),
		.aligned(aligned), .scanDone(scanDone), .responseMs(responseMs),
		.thirdAllClear(thirdAllClear), .thirdAnyClear(thirdAnyClear),
		.txLed1(txLed1), .txLed2(txLed2), .rxLed1(rxLed1),
		.rxYellow(rxYellow), .rxBlue(rxBlue), .segments(segments),
		.inSync(inSync), .lockedOut(lockedOut), .errorActive(errorActive),
		.scanStrobe(scanStrobe));

	machine_control #(.SCAN(16)) partner (.clock(clock), .sys_rst(sys_rst),
		.scanDone(scanDone));

	// Mismatch report and tally
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	// Pins pass a resync chain, so levels get a few edges to land
	task automatic wait_n(input int n);
		repeat (n) @(negedge clock);
	endtask : wait_n

	task automatic power_on();
		@(negedge clock);
		sys_rst = 1'b1;
		wait_n(12);
		sys_rst = 1'b0;
	endtask : power_on

	task automatic t_power_up();
		wait_n(10);
		check("self test glyph", 8'(segments), 8'(`SEG_ALL));
		wait_n(40);
		check("response glyph", 8'(segments), 8'(`SEG_T));
		wait_n(70);
		check("mode one glyph", 8'(segments), 8'h06);
		opModeFive = 1'b1;
		wait_n(8);
		check("mode five glyph", 8'(segments), 8'h6d);
		opModeFive = 1'b0;
		opModeNum = 3'h4;
		wait_n(8);
		check("rotated one glyph", 8'(segments), 8'h30);
		opModeNum = 3'h1;
		wait_n(8);
		$display("power up test done");
	endtask : t_power_up

	task automatic t_tx();
		check("tx led normal", 8'(txLed1), 8'h01);
		txFault = 1'b1;
		wait_n(8);
		check("tx led fault", 8'(txLed1), 8'h02);
		txFault = 1'b0;
		check("channel one led", 8'(txLed2), 8'h00);
		channel_two = 1'b1;
		wait_n(8);
		check("channel two led", 8'(txLed2), 8'h01);
		channel_two = 1'b0;
		$display("transmitter test done");
	endtask : t_tx

	task automatic t_leds();
		check("rx led off", 8'(rxLed1), 8'h02);
		safety_output_pair = 1'b1;
		wait_n(8);
		check("rx led on", 8'(rxLed1), 8'h01);
		safety_output_pair = 1'b0;
		restart_interlock = '{inhibited: 1'b0, active: 1'b1, blocked: 1'b1};
		wait_n(8);
		check("yellow unlockable", 8'(rxYellow), 8'h01);
		thirdAllClear = 3'h3;
		wait_n(8);
		check("yellow field cut", 8'(rxYellow), 8'h00);
		thirdAllClear = 3'h7;
		restart_interlock = '{inhibited: 1'b1, active: 1'b0, blocked: 1'b0};
		wait_n(8);
		check("yellow inhibited", 8'(rxYellow), 8'h00);
		controllerGating = 1'b1;
		wait_n(8);
		check("yellow gating", 8'(rxYellow), 8'h01);
		controllerGating = 1'b0;
		check("blue idle", 8'(rxBlue), 8'h00);
		blankTaught = 1'b1;
		wait_n(8);
		check("blue taught", 8'(rxBlue), 8'h01);
		blankTaught = 1'b0;
		$display("led test done");
	endtask : t_leds

	task automatic raise_fault(input err_class_t cls, input logic blk);
		@(negedge clock);
		faultIn = '{errClass: cls, blocking: blk, code: 8'h12};
		faultValid = 1'b1;
		@(negedge clock);
		faultValid = 1'b0;
		wait_n(4);
	endtask : raise_fault

	task automatic t_errors();
		err_class_t cls[3];
		logic [6:0] glyph[3];
		cls = '{ERR_INTERNAL, ERR_EXTERNAL, ERR_USAGE};
		glyph = '{`SEG_F, `SEG_E, `SEG_U};
		for (int i = 0; i < 3; i++) begin
			raise_fault(cls[i], 1'b0);
			check("error flag", 8'(errorActive), 8'h01);
			check("class letter", 8'(segments), 8'(glyph[i]));
			check("rx red in error", 8'(rxLed1.red), 8'h01);
			wait_n(20);
			check("code high digit", 8'(segments), 8'h06);
			wait_n(RC + 20);
			check("auto recovery", 8'(errorActive), 8'h00);
			check("outputs held off", 8'(rxLed1), 8'h02);
			check("back to mode", 8'(segments), 8'h06);
		end
		$display("error test done");
	endtask : t_errors

	task automatic t_block();
		raise_fault(ERR_INTERNAL, 1'b1);
		check("locked", 8'(lockedOut), 8'h01);
		wait_n(2 * RC);
		check("still locked", 8'(lockedOut), 8'h01);
		check("error kept", 8'(errorActive), 8'h01);
		power_on();
		wait_n(130);
		check("unlocked by power", 8'(lockedOut), 8'h00);
		$display("lockout test done");
	endtask : t_block

	task automatic t_align();
		aligned = 1'b0;
		thirdAllClear = 3'h4;
		thirdAnyClear = 3'h4;
		wait_n(8);
		check("upper third", 8'(segments), 8'(`SEG_ALIGN_TOP));
		thirdAllClear = 3'h1;
		thirdAnyClear = 3'h1;
		wait_n(8);
		check("lower third", 8'(segments), 8'(`SEG_ALIGN_BOT));
		thirdAllClear = 3'h7;
		thirdAnyClear = 3'h7;
		aligned = 1'b1;
		wait_n(8);
		check("all thirds", 8'(segments), 8'h49);
		wait_n(50);
		check("align exit", 8'(segments), 8'h06);
		$display("alignment test done");
	endtask : t_align

	task automatic t_sync();
		int seen;
		seen = 0;
		syncBeamA = 1'b0;
		wait_n(8);
		check("sync one beam", 8'(inSync), 8'h01);
		syncBeamB = 1'b0;
		wait_n(8);
		check("sync lost", 8'(inSync), 8'h00);
		syncBeamA = 1'b1;
		syncBeamB = 1'b1;
		// Let the resync chain settle so the window spans two whole scans
		wait_n(8);
		for (int i = 0; i < 32; i++) begin
			@(posedge clock);
			#1;
			if (scanStrobe === 1'b1) begin
				seen++;
			end
		end
		check("scan strobes", 8'(seen), 8'h02);
		$display("sync test done");
	endtask : t_sync

	initial begin
		power_on();
		t_power_up();
		t_tx();
		t_leds();
		t_errors();
		t_block();
		t_align();
		t_sync();
		results();
	end

	// Watchdog sized well past the expected run length
	initial begin
		#(8 * 20000);
		miscompares++;
		results();
	end
endmodule : light_curtain_status_indicator_tb
